// ### logic/lcp_pkg.sv
// lcp_pkg: register map, field positions, reset values and divider figures
// for the lcd clock and segment pin select block.
// assumes an 8-bit processor data path with 16-bit addresses.
package lcp_pkg;

    // register addresses
    localparam logic [15:0] ADDR_KEY_RETURN_MODE  = 16'hff6e;
    localparam logic [15:0] ADDR_UART_TX_PIN_FUNC = 16'hff20;
    localparam logic [15:0] ADDR_LCD_CLOCK_CTRL   = 16'hffb2;
    localparam logic [15:0] ADDR_SEG_PIN_SEL_LOW  = 16'hffb5;
    localparam logic [15:0] ADDR_SEG_GROUP_SEL    = 16'hffb6;

    // reset values
    localparam logic [7:0] RST_KEY_RETURN_MODE  = 8'h00;
    localparam logic [7:0] RST_UART_TX_PIN_FUNC = 8'h00;
    localparam logic [7:0] RST_LCD_CLOCK_CTRL   = 8'h00;
    localparam logic [7:0] RST_SEG_PIN_SEL_LOW  = 8'h00;
    localparam logic [7:0] RST_SEG_GROUP_SEL    = 8'h00;

    // writable bit masks; other bits read as zero
    localparam logic [7:0] WMASK_UART_TX_PIN_FUNC = 8'h08;
    localparam logic [7:0] WMASK_LCD_CLOCK_CTRL   = 8'h77;
    localparam logic [7:0] WMASK_SEG_GROUP_SEL    = 8'h7f;
    localparam logic [7:0] WMASK_FULL             = 8'hff;
    localparam logic [7:0] WMASK_SMALL_PIN_SEL    = 8'hfc;

    // field positions
    localparam int SHARED_PIN_FUNC_POS = 3;
    localparam int SRC_SEL_LSB         = 4;
    localparam int LCD_DIV_SEL_LSB     = 0;

    // source clock select codes
    localparam logic [2:0] SRC_SUB_OSC   = 3'h0;
    localparam logic [2:0] SRC_PERIPH_6  = 3'h1;
    localparam logic [2:0] SRC_PERIPH_7  = 3'h2;
    localparam logic [2:0] SRC_PERIPH_8  = 3'h3;
    localparam logic [2:0] SRC_LOW_SPEED = 3'h4;

    // divider exponents (divide by two to the power given)
    localparam logic [3:0] PERIPH_EXP_BASE = 4'h6;
    localparam logic [3:0] LOW_SPEED_EXP   = 4'h3;
    localparam logic [3:0] LCD_EXP_BASE    = 4'h4;
    localparam logic [2:0] LCD_SEL_MAX     = 3'h5;

    // counter widths for the dividers
    localparam int PERIPH_CNT_W    = 8;
    localparam int LOW_SPEED_CNT_W = 3;
    localparam int LCD_CNT_W       = 9;

endpackage : lcp_pkg

// ### logic/lcp_pow2_div.sv
// lcp_pow2_div: free-running power-of-two prefix divider on clock enables.
// assumes tick_in is a one-cycle enable in the core_clk domain.
`timescale 1ns/100ps
module lcp_pow2_div #(
    parameter int CNT_W = 9
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             tick_in,
    input  wire logic [3:0]       exp_req,
    input  wire logic             exp_ok,
    output logic                  tick_out
);

    generate
        if (CNT_W < 1 || CNT_W > 15) begin : g_bad_width
            $error("lcp_pow2_div: CNT_W must be 1 to 15");
        end
    endgenerate

    logic [CNT_W-1:0] cnt;
    logic [3:0]       exp_act;
    logic             ok_act;
    logic [CNT_W-1:0] mask;
    logic             wrap;

    // mask of the low exp_act bits; a full prefix of ones ends a period
    assign mask = CNT_W'((16'h0001 << exp_act) - 16'h0001);
    assign wrap = tick_in && ((cnt & mask) == mask);

    // free-running count, never reloaded, so a new divide ratio shares phase
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cnt <= '0;
        end else if (tick_in) begin
            cnt <= cnt + CNT_W'(1);
        end
    end

    // a changed selection takes hold at the end of the running period, or at once while the output is stopped
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            exp_act <= 4'h0;
            ok_act  <= 1'b0;
        end else if (wrap || !ok_act) begin
            exp_act <= exp_req;
            ok_act  <= exp_ok;
        end
    end

    // one-cycle enable out; a prohibited code stops the output
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tick_out <= 1'b0;
        end else begin
            tick_out <= wrap && ok_act;
        end
    end

endmodule : lcp_pow2_div

// ### logic/lcp_pin_select.sv
// lcp_pin_select: lcd source clock and lcd clock selection, frame tick,
// segment pin selection, shared uart transmit pin routing and key return mode.
// assumes the processor writes bytes or single bits through the cpu_* port,
// and that the oscillator clocks and pin input are asynchronous levels.
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////
// Function
// - source clock: sub oscillator, peripheral clock /64,/128,/256, low speed osc /8
// - lcd clock is source divided by 16 up to 512 per 3-bit code
// - shared pin function bit routes pin to general use or uart transmit
// - each pin select bit, bar bits 0 and 1 on the small variant, makes its pin port (0) or segment output (1)
// - group select bits switch whole port groups to segment outputs
// - key return mode bits mark pins as key scan inputs
// - reset clears pin function, group select and key return mode registers
// - registers take single-bit and whole-byte writes without disturbing others
// - frame rate follows lcd clock and number of time slices
module lcp_pin_select #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    // processor register port
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_byte_we,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_bit_we,
    input  wire logic [2:0]  cpu_bit_sel,
    input  wire logic        cpu_bit_val,
    input  wire logic        cpu_rd,
    output logic [7:0]       cpu_rdata,
    output logic             cpu_rvalid,
    // clock sources
    input  wire logic        sub_oscillator_clock,
    input  wire logic        low_speed_osc_clock,
    // display mode from the lcd mode logic, lcd clock and frame tick out
    input  wire logic [3:0]  time_slices,
    input  wire logic        key_scan_on,
    output logic             lcd_div_clock,
    output logic             frame_tick,
    // shared key input / uart transmit pin
    input  wire logic        shared_pin_in,
    input  wire logic        port_out,
    input  wire logic        port_oe,
    input  wire logic        serial_out_line,
    input  wire logic        serial_out_en,
    input  wire logic        uart_a_transmit,
    input  wire logic        uart_b_transmit,
    output logic             shared_pin_out,
    output logic             shared_pin_oe,
    output logic             key_input_4,
    output logic             shared_pin_function_bit,
    // segment and key scan selections
    output logic [7:0]       pin_segment_select_bit,
    output logic [7:0]       group_segment_select_bit,
    output logic [7:0]       key_scan_input_sel
);

    // merge a byte or single-bit write into a register, keeping fixed bits zero
    function automatic logic [7:0] lcp_merge(
        input logic [7:0] cur,
        input logic       byte_we,
        input logic [7:0] wdata,
        input logic       bit_we,
        input logic [2:0] bsel,
        input logic       bval,
        input logic [7:0] wmask
    );
        logic [7:0] res;
        res = cur;
        if (byte_we) begin
            res = wdata;
        end else if (bit_we) begin
            res[bsel] = bval;
        end
        return res & wmask;
    endfunction : lcp_merge

    localparam logic [7:0] PIN_SEL_MASK = SMALL_VARIANT ? lcp_pkg::WMASK_SMALL_PIN_SEL
                                                        : lcp_pkg::WMASK_FULL;

    logic [7:0] uart_tx_pin_function;
    logic [7:0] lcd_clock_control;
    logic [7:0] segment_pin_select_low;
    logic [7:0] segment_group_select;
    logic [7:0] key_return_mode;

    logic       sel_pf;
    logic       sel_cc;
    logic       sel_ps;
    logic       sel_gs;
    logic       sel_kr;

    //////////////////////////////////////////////////////////////////////////
    // register file

    assign sel_pf = (cpu_addr == lcp_pkg::ADDR_UART_TX_PIN_FUNC);
    assign sel_cc = (cpu_addr == lcp_pkg::ADDR_LCD_CLOCK_CTRL);
    assign sel_ps = (cpu_addr == lcp_pkg::ADDR_SEG_PIN_SEL_LOW);
    assign sel_gs = (cpu_addr == lcp_pkg::ADDR_SEG_GROUP_SEL);
    assign sel_kr = (cpu_addr == lcp_pkg::ADDR_KEY_RETURN_MODE);

    // shared pin function register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            uart_tx_pin_function <= lcp_pkg::RST_UART_TX_PIN_FUNC;
        end else if (sel_pf) begin
            uart_tx_pin_function <= lcp_merge(uart_tx_pin_function, cpu_byte_we, cpu_wdata,
                cpu_bit_we, cpu_bit_sel, cpu_bit_val, lcp_pkg::WMASK_UART_TX_PIN_FUNC);
        end
    end

    // clock control; bits 3 and 7 are held at zero whatever is written
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lcd_clock_control <= lcp_pkg::RST_LCD_CLOCK_CTRL;
        end else if (sel_cc) begin
            lcd_clock_control <= lcp_merge(lcd_clock_control, cpu_byte_we, cpu_wdata,
                cpu_bit_we, cpu_bit_sel, cpu_bit_val, lcp_pkg::WMASK_LCD_CLOCK_CTRL);
        end
    end

    // per-pin segment select; low two bits fixed on the small variant
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            segment_pin_select_low <= lcp_pkg::RST_SEG_PIN_SEL_LOW;
        end else if (sel_ps) begin
            segment_pin_select_low <= lcp_merge(segment_pin_select_low, cpu_byte_we,
                cpu_wdata, cpu_bit_we, cpu_bit_sel, cpu_bit_val, PIN_SEL_MASK);
        end
    end

    // group segment select; bit 7 has no group
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            segment_group_select <= lcp_pkg::RST_SEG_GROUP_SEL;
        end else if (sel_gs) begin
            segment_group_select <= lcp_merge(segment_group_select, cpu_byte_we, cpu_wdata,
                cpu_bit_we, cpu_bit_sel, cpu_bit_val, lcp_pkg::WMASK_SEG_GROUP_SEL);
        end
    end

    // key return mode
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            key_return_mode <= lcp_pkg::RST_KEY_RETURN_MODE;
        end else if (sel_kr) begin
            key_return_mode <= lcp_merge(key_return_mode, cpu_byte_we, cpu_wdata,
                cpu_bit_we, cpu_bit_sel, cpu_bit_val, lcp_pkg::WMASK_FULL);
        end
    end

    // read data one cycle after the strobe; unmapped addresses read zero
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            cpu_rdata  <= 8'h00;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= cpu_rd;
            if (cpu_rd) begin
                cpu_rdata <= ({8{sel_pf}} & uart_tx_pin_function)
                           | ({8{sel_cc}} & lcd_clock_control)
                           | ({8{sel_ps}} & segment_pin_select_low)
                           | ({8{sel_gs}} & segment_group_select)
                           | ({8{sel_kr}} & key_return_mode);
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // oscillator and pin synchronisers

    logic [2:0] sub_sync;
    logic [2:0] low_sync;
    logic [1:0] pin_sync;

    // third stage only feeds edge detection; first stage feeds only the second
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            sub_sync <= 3'h0;
            low_sync <= 3'h0;
            pin_sync <= 2'h3;
        end else begin
            sub_sync <= {sub_sync[1:0], sub_oscillator_clock};
            low_sync <= {low_sync[1:0], low_speed_osc_clock};
            pin_sync <= {pin_sync[0], shared_pin_in};
        end
    end

    logic sub_tick;
    logic low_tick;

    // rising edges of the slow oscillators become core_clk enables
    assign sub_tick = sub_sync[1] && !sub_sync[2];
    assign low_tick = low_sync[1] && !low_sync[2];

    //////////////////////////////////////////////////////////////////////////
    // lcd source clock and lcd clock

    logic [2:0] src_sel;
    logic [2:0] lcd_sel;
    logic       periph_tick;
    logic       low_div_tick;
    logic       src_tick;
    logic       periph_ok;
    logic [3:0] periph_exp;
    logic [3:0] lcd_exp;

    assign src_sel    = lcd_clock_control[lcp_pkg::SRC_SEL_LSB +: 3];
    assign lcd_sel    = lcd_clock_control[lcp_pkg::LCD_DIV_SEL_LSB +: 3];
    assign periph_ok  = (src_sel >= lcp_pkg::SRC_PERIPH_6) && (src_sel <= lcp_pkg::SRC_PERIPH_8);
    assign periph_exp = lcp_pkg::PERIPH_EXP_BASE + {1'b0, src_sel} - 4'h1;
    assign lcd_exp    = lcp_pkg::LCD_EXP_BASE + {1'b0, lcd_sel};

    // peripheral clock prescaler: divide by 64, 128 or 256
    lcp_pow2_div #(.CNT_W(lcp_pkg::PERIPH_CNT_W)) u_periph_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (1'b1),
        .exp_req  (periph_exp),
        .exp_ok   (periph_ok),
        .tick_out (periph_tick)
    );

    // low speed oscillator divided by 8
    lcp_pow2_div #(.CNT_W(lcp_pkg::LOW_SPEED_CNT_W)) u_low_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (low_tick),
        .exp_req  (lcp_pkg::LOW_SPEED_EXP),
        .exp_ok   (1'b1),
        .tick_out (low_div_tick)
    );

    // source select; prohibited codes stop the lcd clock rather than guess
    always_comb begin
        case (src_sel)
            lcp_pkg::SRC_SUB_OSC:   src_tick = sub_tick;
            lcp_pkg::SRC_PERIPH_6,
            lcp_pkg::SRC_PERIPH_7,
            lcp_pkg::SRC_PERIPH_8:  src_tick = periph_tick;
            lcp_pkg::SRC_LOW_SPEED: src_tick = low_div_tick;
            default:                src_tick = 1'b0;
        endcase
    end

    // lcd clock: source divided by 16 to 512
    lcp_pow2_div #(.CNT_W(lcp_pkg::LCD_CNT_W)) u_lcd_div (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .tick_in  (src_tick),
        .exp_req  (lcd_exp),
        .exp_ok   (lcd_sel <= lcp_pkg::LCD_SEL_MAX),
        .tick_out (lcd_div_clock)
    );

    //////////////////////////////////////////////////////////////////////////
    // frame tick

    logic [4:0] slice_cnt;
    logic [4:0] frame_len;

    // key scan adds slices+1 extra slices to every frame
    assign frame_len = key_scan_on ? ({1'b0, time_slices} << 1) + 5'h01
                                   : {1'b0, time_slices};

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            slice_cnt  <= 5'h00;
            frame_tick <= 1'b0;
        end else begin
            frame_tick <= 1'b0;
            if (lcd_div_clock) begin
                if (slice_cnt + 5'h01 >= frame_len) begin
                    slice_cnt  <= 5'h00;
                    frame_tick <= 1'b1;
                end else begin
                    slice_cnt <= slice_cnt + 5'h01;
                end
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pin routing

    assign shared_pin_function_bit = uart_tx_pin_function[lcp_pkg::SHARED_PIN_FUNC_POS];

    // shared pin: uart transmit when set, else serial out or general port
    always_comb begin
        if (shared_pin_function_bit) begin
            shared_pin_out = uart_a_transmit & uart_b_transmit;
            shared_pin_oe  = 1'b1;
        end else if (serial_out_en) begin
            shared_pin_out = serial_out_line;
            shared_pin_oe  = 1'b1;
        end else begin
            shared_pin_out = port_out;
            shared_pin_oe  = port_oe;
        end
    end

    // key input idles high while the pin carries uart data
    assign key_input_4 = shared_pin_function_bit ? 1'b1 : pin_sync[1];

    assign pin_segment_select_bit   = segment_pin_select_low;
    assign group_segment_select_bit = segment_group_select;

    // key return bits only claim pins while key scan runs
    assign key_scan_input_sel = key_scan_on ? key_return_mode : 8'h00;

endmodule : lcp_pin_select

// ### bench/lcp_pad_model.sv
// lcp_pad_model: the shared key input / uart transmit pad as the panel side sees it.
// assumes one key contact that pulls the line low, with an on-pad pull-up.
`timescale 1ns/100ps
module lcp_pad_model (
    input  wire logic pin_out,
    input  wire logic pin_oe,
    input  wire logic key_press,
    output logic      pin_level
);
    // a released line never keeps the last driven value: the pull-up wins unless the key is pressed
    assign pin_level = pin_oe ? pin_out : !key_press;
endmodule : lcp_pad_model

// ### bench/lcp_pin_select_chk.sv
// lcp_pin_select_chk: port-level checks of register writes and pin routing.
// assumes it is bound into every lcp_pin_select with matching port names.
`timescale 1ns/100ps
module lcp_pin_select_chk #(
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_byte_we,
    input wire logic [7:0]  cpu_wdata,
    input wire logic        cpu_bit_we,
    input wire logic [2:0]  cpu_bit_sel,
    input wire logic        cpu_bit_val,
    input wire logic        cpu_rd,
    input wire logic        cpu_rvalid,
    input wire logic        key_scan_on,
    input wire logic        uart_a_transmit,
    input wire logic        uart_b_transmit,
    input wire logic        lcd_div_clock,
    input wire logic        frame_tick,
    input wire logic        shared_pin_out,
    input wire logic        shared_pin_oe,
    input wire logic        key_input_4,
    input wire logic        shared_pin_function_bit,
    input wire logic [7:0]  pin_segment_select_bit,
    input wire logic [7:0]  group_segment_select_bit,
    input wire logic [7:0]  key_scan_input_sel
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    //////////////////////////////////////////////////////////////////////////
    // register port: read answer and writes, byte and single bit
    property p_rvalid; cpu_rd |=> cpu_rvalid; endproperty
    a_rvalid: assert property (p_rvalid) else $error("read not answered");
    property p_pin_byte;
        cpu_byte_we && cpu_addr == lcp_pkg::ADDR_SEG_PIN_SEL_LOW |=> pin_segment_select_bit ==
            ($past(cpu_wdata) & (SMALL_VARIANT ? lcp_pkg::WMASK_SMALL_PIN_SEL : 8'hff));
    endproperty
    a_pin_byte: assert property (p_pin_byte) else $error("pin select byte lost");
    // a bit write may touch only the addressed bit; bit 7 stays zero
    property p_grp_bit;
        cpu_bit_we && !cpu_byte_we && cpu_addr == lcp_pkg::ADDR_SEG_GROUP_SEL |=>
            ((group_segment_select_bit ^ $past(group_segment_select_bit)) &
             ~(8'h01 << $past(cpu_bit_sel))) == 8'h00 &&
            group_segment_select_bit[$past(cpu_bit_sel)] ==
             ($past(cpu_bit_sel) == 3'h7 ? 1'b0 : $past(cpu_bit_val));
    endproperty
    a_grp_bit: assert property (p_grp_bit) else $error("group bit write wrong");
    property p_grp7; group_segment_select_bit[7] == 1'b0; endproperty
    a_grp7: assert property (p_grp7) else $error("group bit 7 set");
    property p_fn_byte;
        cpu_byte_we && cpu_addr == lcp_pkg::ADDR_UART_TX_PIN_FUNC |=>
            shared_pin_function_bit == $past(cpu_wdata[3]);
    endproperty
    a_fn_byte: assert property (p_fn_byte) else $error("shared pin bit lost");
    // reset is sampled, so it needs its own disable condition
    property p_rst;
        @(posedge core_clk) disable iff (1'b0) !rst_n |=> pin_segment_select_bit == 8'h00 &&
            group_segment_select_bit == 8'h00 && !shared_pin_function_bit;
    endproperty
    a_rst: assert property (p_rst) else $error("reset left a selection set");
    //////////////////////////////////////////////////////////////////////////
    // pin routing and clock enable shape
    property p_uart;
        shared_pin_function_bit |-> shared_pin_oe && key_input_4 &&
            shared_pin_out == (uart_a_transmit & uart_b_transmit);
    endproperty
    a_uart: assert property (p_uart) else $error("uart routing wrong");
    property p_key_sel; !key_scan_on |-> key_scan_input_sel == 8'h00; endproperty
    a_key_sel: assert property (p_key_sel) else $error("key scan select leaks");
    property p_lcd_pulse; lcd_div_clock |=> !lcd_div_clock [*8]; endproperty
    a_lcd_pulse: assert property (p_lcd_pulse) else $error("lcd enable too wide");
    property p_frame; frame_tick |-> $past(lcd_div_clock); endproperty
    a_frame: assert property (p_frame) else $error("frame tick without lcd tick");
    c_uart: cover property (shared_pin_function_bit && shared_pin_oe);
    c_bitw: cover property (cpu_bit_we && !cpu_byte_we);
    c_key: cover property (key_scan_on && key_scan_input_sel != 8'h00);
    c_lcd: cover property (lcd_div_clock);
endmodule : lcp_pin_select_chk

bind lcp_pin_select lcp_pin_select_chk #(.SMALL_VARIANT(SMALL_VARIANT)) i_lcp_pin_select_chk (.*);

// ### bench/lcp_pin_select_test.sv
// lcp_pin_select_test: registers, pin routing and lcd clock periods.
// assumes the checker is bound in and the pad model closes the shared pin.
`timescale 1ns/100ps
module lcp_pin_select_test;
    localparam logic [15:0] ADR [6] = '{lcp_pkg::ADDR_UART_TX_PIN_FUNC,
        lcp_pkg::ADDR_LCD_CLOCK_CTRL, lcp_pkg::ADDR_SEG_PIN_SEL_LOW,
        lcp_pkg::ADDR_SEG_GROUP_SEL, lcp_pkg::ADDR_KEY_RETURN_MODE, 16'hff00};
    localparam logic [7:0]  MSK [6] = '{lcp_pkg::WMASK_UART_TX_PIN_FUNC,
        lcp_pkg::WMASK_LCD_CLOCK_CTRL, 8'hff, lcp_pkg::WMASK_SEG_GROUP_SEL, 8'hff, 8'h00};
    logic        core_clk = 1'b0, rst_n = 1'b0, cpu_byte_we = 1'b0, cpu_bit_we = 1'b0;
    logic        cpu_bit_val = 1'b0, cpu_rd = 1'b0, sub_osc = 1'b0, low_osc = 1'b0;
    logic        key_scan_on = 1'b0, port_out = 1'b0, port_oe = 1'b0, ser_out = 1'b0;
    logic        ser_en = 1'b0, uart_a = 1'b1, uart_b = 1'b1, key_press = 1'b0, pin_in;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00, cpu_rdata, pin_sel, grp_sel, key_sel;
    logic [2:0]  cpu_bit_sel = 3'h0;
    logic [3:0]  slices;
    logic        cpu_rvalid, lcd_clk, frame_tick, pin_out, pin_oe, key_in, fn_bit;
    logic [7:0]  shad [6];
    logic [7:0]  exq [$];
    int          num_errors = 0, n_checks = 0, seed = 9, rv, k, fcnt = 0;
    lcp_pin_select i_lcp_pin_select (.core_clk(core_clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
        .cpu_byte_we(cpu_byte_we), .cpu_wdata(cpu_wdata), .cpu_bit_we(cpu_bit_we),
        .cpu_bit_sel(cpu_bit_sel), .cpu_bit_val(cpu_bit_val), .cpu_rd(cpu_rd),
        .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .sub_oscillator_clock(sub_osc),
        .low_speed_osc_clock(low_osc), .time_slices(slices), .key_scan_on(key_scan_on),
        .lcd_div_clock(lcd_clk), .frame_tick(frame_tick), .shared_pin_in(pin_in),
        .port_out(port_out), .port_oe(port_oe), .serial_out_line(ser_out),
        .serial_out_en(ser_en), .uart_a_transmit(uart_a), .uart_b_transmit(uart_b),
        .shared_pin_out(pin_out), .shared_pin_oe(pin_oe), .key_input_4(key_in),
        .shared_pin_function_bit(fn_bit), .pin_segment_select_bit(pin_sel),
        .group_segment_select_bit(grp_sel), .key_scan_input_sel(key_sel));
    lcp_pad_model i_lcp_pad_model (.pin_out(pin_out), .pin_oe(pin_oe),
        .key_press(key_press), .pin_level(pin_in));
    //////////////////////////////////////////////////////////////////////////
    // clock and slow oscillator levels; the oscillators never stop
    initial begin
        forever #10 core_clk = ~core_clk;
    end
    initial begin
        forever begin
            repeat (763) @(posedge core_clk);
            #2 sub_osc = ~sub_osc;
        end
    end
    initial begin
        forever begin
            repeat (97) @(posedge core_clk);
            #2 low_osc = ~low_osc;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    // compare tasks and the closing report
    task cmp(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    task cmp_per(input int got, input int exp);
        n_checks++;
        if (got != exp) begin
            num_errors++;
            $display("ERROR t=%0t period got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_per
    task finish_test;
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : finish_test
    // read answers are matched to notes in issue order
    always @(posedge core_clk) begin
        if (cpu_rvalid === 1'b1 && exq.size() > 0) cmp(cpu_rdata, exq.pop_front());
    end
    // lcd ticks per frame; reset restarts both counts
    always @(posedge core_clk) begin
        if (!rst_n) fcnt = 0;
        else if (frame_tick === 1'b1) begin
            cmp(8'(fcnt), {4'h0, slices});
            fcnt = 0;
        end else if (lcd_clk === 1'b1) fcnt++;
    end
    //////////////////////////////////////////////////////////////////////////
    // register port cycles; each leaves one idle cycle behind it
    task wr(input int i, input logic [7:0] d);
        @(posedge core_clk);
        #2 cpu_addr = ADR[i];
        cpu_wdata = (i == 1) ? d & 8'h77 : d;
        cpu_byte_we = 1'b1;
        @(posedge core_clk);
        #2 cpu_byte_we = 1'b0;
        shad[i] = d & MSK[i];
    endtask : wr
    task bw(input int i, input logic [2:0] s, input logic v);
        @(posedge core_clk);
        #2 cpu_addr = ADR[i];
        cpu_bit_sel = s;
        cpu_bit_val = v && !(i == 1 && s[1:0] == 2'h3);
        cpu_bit_we = 1'b1;
        @(posedge core_clk);
        #2 cpu_bit_we = 1'b0;
        shad[i][s] = v & MSK[i][s];
    endtask : bw
    task rd(input int i);
        exq.push_back(shad[i]);
        @(posedge core_clk);
        #2 cpu_addr = ADR[i];
        cpu_rd = 1'b1;
        @(posedge core_clk);
        #2 cpu_rd = 1'b0;
    endtask : rd
    // period between the 2nd and 3rd enable after a settling wait that follows a new code; exp 0 means stopped
    task meas(input logic [7:0] code, input int exp, input int span);
        int n, cyc, last;
        wr(1, code);
        n = 0;
        cyc = 0;
        last = 0;
        repeat (exp == 0 ? 4200 : 1100) @(posedge core_clk);
        while (n < 3 && cyc < span) begin
            @(posedge core_clk);
            cyc++;
            if (lcd_clk === 1'b1) begin
                n++;
                if (n == 3) cmp_per(cyc - last, exp);
                last = cyc;
            end
        end
        if (exp == 0) cmp_per(n, 0);
        else if (n < 3) cmp_per(0, exp);
    endtask : meas
    //////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        slices = 4'h1 + {2'h0, 2'($random(seed))};
        for (k = 0; k < 6; k++) shad[k] = 8'h00;
        repeat (5) @(posedge core_clk);
        #2 rst_n = 1'b1;
        for (k = 0; k < 6; k++) rd(k);
        repeat (16) begin
            rv = $random(seed);
            k = rv[15:8] % 6;
            wr(k, rv[7:0]);
            rd(k);
            bw(k, rv[18:16], rv[19]);
            bw(3, rv[22:20], rv[23]);
            rd(k);
            #1 cmp(pin_sel, shad[2]);
            cmp(grp_sel, shad[3]);
            cmp({7'h0, fn_bit}, {7'h0, shad[0][3]});
        end
        // shared pin: key level through the pad, then uart, then port drive
        wr(0, 8'h00);
        port_oe = 1'b0;
        key_press = 1'b1;
        repeat (4) @(posedge core_clk);
        #1 cmp({7'h0, key_in}, 8'h00);
        key_press = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 cmp({7'h0, key_in}, 8'h01);
        rv = $random(seed);
        uart_a = rv[0];
        uart_b = rv[1];
        port_oe = 1'b1;
        port_out = rv[2];
        wr(0, 8'h08);
        #1 cmp({6'h0, pin_oe, pin_out}, {6'h0, 1'b1, rv[0] & rv[1]});
        wr(0, 8'h00);
        #1 cmp({6'h0, pin_oe, pin_out}, {6'h0, 1'b1, rv[2]});
        ser_en = 1'b1;
        ser_out = !rv[2];
        #1 cmp({6'h0, pin_oe, pin_out}, {6'h0, 1'b1, !rv[2]});
        meas(8'h50, 0, 3000);
        // key return bits reach key_scan_input_sel only while key scan runs
        #2 key_scan_on = 1'b1;
        wr(4, rv[15:8]);
        #1 cmp(key_sel, shad[4]);
        key_scan_on = 1'b0;
        #1 cmp(key_sel, 8'h00);
        meas(8'h10, 1024, 4000);
        meas(8'h21, 4096, 14000);
        meas(8'h16, 0, 3000);
        meas(8'h30, 4096, 14000);
        meas(8'h12, 4096, 14000);
        // second reset in mid-run clears everything again
        bw(2, 3'h5, 1'b1);
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        #2 rst_n = 1'b1;
        for (k = 0; k < 6; k++) shad[k] = 8'h00;
        for (k = 0; k < 6; k++) rd(k);
        repeat (4) @(posedge core_clk);
        cmp_per(exq.size(), 0);
        finish_test();
    end
endmodule : lcp_pin_select_test
